/* File: design/nfcfc_pkg.sv */
// Purpose: constants and types for the contactless front end control
// Assumes: 100 MHz core clock, AHB-Lite register access
// Notes:   byte offsets, field positions, reset values and timing counts
package nfcfc_pkg;
	// ****************************************************************
	// register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00; // role, rate, channel control
	localparam logic [7:0] OFS_TXCFG  = 8'h04; // modulation and polarity
	localparam logic [7:0] OFS_RXCFG  = 8'h08; // filter and gain
	localparam logic [7:0] OFS_SENSE  = 8'h0C; // tag sense setup
	localparam logic [7:0] OFS_STATUS = 8'h10; // state, W1C tag flag
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_INITREQ = 0;  // application asks for initiator
	localparam int CTRL_P2PEN   = 1;  // peer-to-peer function on
	localparam int CTRL_RATE    = 2;  // [3:2] data rate
	localparam int CTRL_ACTMOD  = 4;  // 1 = active field modulation
	localparam int CTRL_GAINEN  = 5;  // gain loop run
	localparam int CTRL_CHI     = 6;  // in-phase channel enable
	localparam int CTRL_CHQ     = 7;  // quadrature channel enable
	localparam int CTRL_ADCCARD = 8;  // adc-based card mode
	localparam int CTRL_SENSEEN = 9;  // tag sense enable
	localparam int TX_INVA      = 0;  // invert carrier on output a
	localparam int TX_INVB      = 1;  // invert carrier on output b
	localparam int TX_FULLMOD   = 2;  // 100 percent modulation
	localparam int TX_AMLVL     = 3;  // [5:3] partial modulation level
	localparam int RX_HPF       = 0;  // [1:0] high-pass corner step
	localparam int RX_GAIN      = 2;  // [7:2] gain in dB
	localparam int SN_THR       = 0;  // [7:0] detuning sensitivity
	localparam int SN_BASE      = 8;  // [15:8] detuning baseline
	localparam int ST_ROLE      = 0;  // [1:0] role state
	localparam int ST_FIELD     = 2;  // own field on
	localparam int ST_EXT       = 3;  // external field seen
	localparam int ST_MODEA     = 4;  // type a initiator seen
	localparam int ST_MODEALT   = 5;  // alternative initiator seen
	localparam int ST_TAG       = 6;  // tag sensed, W1C
	localparam int ST_TXN       = 7;  // transaction active
	localparam int ST_GAIN      = 16; // [25:16] gain resistor code
	// ****************************************************************
	// rates, reset values, timing
	// ****************************************************************
	localparam logic [1:0] RATE_106 = 2'h0;
	localparam logic [1:0] RATE_212 = 2'h1;
	localparam logic [1:0] RATE_424 = 2'h2;
	localparam logic [5:0] GAIN_DB_MIN = 6'h1E; // 30 dB
	localparam logic [5:0] GAIN_DB_MAX = 6'h3C; // 60 dB
	localparam logic [9:0] GAIN_CODE_RST = 10'h000; // highest resistance
	localparam logic [9:0] GAIN_CODE_MAX = 10'h3FF; // half resistance
	localparam int CLK_PERIOD_NS = 10;
	localparam int IDT_TIME_NS   = 5000; // listen time before field on
	localparam int IDT_CYCLES    = (IDT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAIN_SAMPLE   = 16;   // cycles per comparator sample
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {ROLE_TARGET, ROLE_LISTEN, ROLE_INIT, ROLE_XCHG} nfcfc_role_e;
	typedef struct packed {
		nfcfc_role_e role;
		logic [15:0] idtCnt;
		logic [3:0]  sampCnt;
		logic [9:0]  ctrl;
		logic [5:0]  txCfg;
		logic [7:0]  rxCfg;
		logic [15:0] sense;
		logic [9:0]  gainCode;
		logic        tagFlag;
		logic        modeA;
		logic        modeAlt;
		logic        initPulse;
		logic        txA;
		logic        txB;
		logic        apValid;
		logic        apWrite;
		logic [7:0]  apAddr;
		logic [31:0] rdata;
	} nfcfc_state_s;
endpackage : nfcfc_pkg

/* File: design/nfcfc_top.sv */
// Purpose: digital control of the contactless front end
// Assumes: all inputs synchronous to core_clk, single AHB-Lite slave
// Notes:   analog stages are reached through plain control outputs
`timescale 1ns/1ps
// Functional notes
// - 106 uses type A, others alternative framing
// - rate fixed during a transaction
// - reset into target role, field off
// - level detector on while peer-to-peer
// - initiator only on application request
// - field on after quiet initial delay
// - initiator starts init for selected mode
// - carrier on both outputs, selectable inversion (active target answer always drives both outputs inverted)
// - full and partial amplitude modulation
// - four high-pass corner steps
// - gain configurable 30 to 60 dB
// - separate I/Q enables, card uses I
// - gain loop follows comparator until match
// - ten-bit resistor code, zero is highest
// - comparator watches positive input only
// - mode detector reports initiator type
// - tag sense by detuning, adjustable sensitivity
// - selectable passive or active load modulation
// - target emulates type A and active
module nfcfc_top #(
	parameter int IdtCycles = nfcfc_pkg::IDT_CYCLES // listen window length
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	input  wire logic              carrierClk,  // 13.56 MHz carrier
	input  wire logic              txEnvelope,  // 1 = modulation pause
	input  wire logic              extFieldDet, // level detector output
	input  wire logic              peakHigh,    // comparator on rx_in_pos
	input  wire logic              peakMatch,   // peak at reference
	input  wire logic              modeIsTypeA, // demod saw type A
	input  wire logic              modeIsAlt,   // demod saw alternative
	input  wire logic              initDone,    // initialization finished
	input  wire logic              tgtSession,  // target transaction open
	input  wire logic              loadModData, // answer subcarrier data
	input  wire logic [7:0]        detuneLevel, // antenna detuning sample
	output logic                   tx_out_a,
	output logic                   tx_out_b,
	output logic                   fieldOn,
	output logic                   levelDetEn,
	output logic                   initStart,
	output logic [1:0]             initMode,
	output logic                   framingAlt,
	output logic                   fullMod,
	output logic [2:0]             modLevel,
	output logic [1:0]             hpfSel,
	output logic [5:0]             bbaGainDb,
	output logic                   chanIEn,
	output logic                   chanQEn,
	output logic [9:0]             gain_resistor_code,
	output logic                   passive_field_modulation,
	output logic                   active_field_modulation,
	output logic                   tagSensed
);
	import nfcfc_pkg::*;

	// ****************************************************************
	// parameter check
	// ****************************************************************
	if (IdtCycles < 2 || IdtCycles > 65535) begin : g_badIdt
		$error("IdtCycles out of range");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	nfcfc_state_s st_q; // all registered state
	nfcfc_state_s st_d; // next state
	logic         txnActive; // rate locked
	logic         wrEn;      // data phase write
	logic         sampTick;  // comparator sample point
	logic         tagHit;    // detuning beyond sensitivity
	logic [7:0]   detDiff;   // distance from baseline

	// clamp a written gain into the legal dB window
	function automatic logic [5:0] clampGain(input logic [5:0] g);
		if (g < GAIN_DB_MIN) begin
			clampGain = GAIN_DB_MIN;
		end else if (g > GAIN_DB_MAX) begin
			clampGain = GAIN_DB_MAX;
		end else begin
			clampGain = g;
		end
	endfunction : clampGain

	assign txnActive = (st_q.role == ROLE_INIT) || (st_q.role == ROLE_XCHG) || tgtSession;
	assign wrEn      = st_q.apValid && st_q.apWrite;
	assign sampTick  = (st_q.sampCnt == 4'(GAIN_SAMPLE - 1));
	assign detDiff   = (detuneLevel > st_q.sense[SN_BASE +: 8])
		? detuneLevel - st_q.sense[SN_BASE +: 8]
		: st_q.sense[SN_BASE +: 8] - detuneLevel;
	assign tagHit    = st_q.ctrl[CTRL_SENSEEN] && (detDiff > st_q.sense[SN_THR +: 8]);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		st_d.initPulse = 1'b0;
		// bus address phase capture
		st_d.apValid = hsel && hready && htrans[1];
		st_d.apWrite = hwrite;
		st_d.apAddr  = haddr;
		// register writes in the data phase
		if (wrEn) begin
			case (st_q.apAddr)
				OFS_CTRL: begin
					st_d.ctrl = hwdata[9:0];
					if (txnActive) begin
						st_d.ctrl[CTRL_RATE +: 2] = st_q.ctrl[CTRL_RATE +: 2];
					end else if (hwdata[CTRL_RATE +: 2] > RATE_424) begin
						st_d.ctrl[CTRL_RATE +: 2] = RATE_424;
					end
				end
				OFS_TXCFG: st_d.txCfg = hwdata[5:0];
				OFS_RXCFG: begin
					st_d.rxCfg[RX_HPF +: 2]  = hwdata[RX_HPF +: 2];
					st_d.rxCfg[RX_GAIN +: 6] = clampGain(hwdata[RX_GAIN +: 6]);
				end
				OFS_SENSE: st_d.sense = hwdata[15:0];
				OFS_STATUS: begin
					if (hwdata[ST_TAG]) begin
						st_d.tagFlag = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// tag sense flag, set wins over clear
		if (tagHit) begin
			st_d.tagFlag = 1'b1;
		end
		// peer-to-peer role sequence
		case (st_q.role)
			ROLE_TARGET: begin
				st_d.idtCnt = 16'h0000;
				if (st_q.ctrl[CTRL_P2PEN] && st_q.ctrl[CTRL_INITREQ]) begin
					st_d.role = ROLE_LISTEN;
				end
			end
			ROLE_LISTEN: begin
				if (!st_q.ctrl[CTRL_INITREQ] || !st_q.ctrl[CTRL_P2PEN]) begin
					st_d.role = ROLE_TARGET;
				end else if (extFieldDet) begin
					st_d.idtCnt = 16'h0000;
				end else if (st_q.idtCnt == 16'(IdtCycles - 1)) begin
					st_d.role      = ROLE_INIT;
					st_d.initPulse = 1'b1;
				end else begin
					st_d.idtCnt = st_q.idtCnt + 16'h0001;
				end
			end
			ROLE_INIT: begin
				if (!st_q.ctrl[CTRL_INITREQ] || !st_q.ctrl[CTRL_P2PEN]) begin
					st_d.role = ROLE_TARGET;
				end else if (initDone) begin
					st_d.role = ROLE_XCHG;
				end
			end
			ROLE_XCHG: begin
				if (!st_q.ctrl[CTRL_INITREQ] || !st_q.ctrl[CTRL_P2PEN]) begin
					st_d.role = ROLE_TARGET;
				end
			end
			default: st_d.role = ROLE_TARGET;
		endcase
		// mode detector, only while listening as target
		if (!extFieldDet) begin
			st_d.modeA   = 1'b0;
			st_d.modeAlt = 1'b0;
		end else if (st_q.role == ROLE_TARGET) begin
			st_d.modeA   = st_q.modeA || modeIsTypeA;
			st_d.modeAlt = st_q.modeAlt || modeIsAlt;
		end
		// gain loop, comparator sees only the positive input
		st_d.sampCnt = st_q.ctrl[CTRL_GAINEN] ? st_q.sampCnt + 4'h1 : 4'h0;
		if (st_q.ctrl[CTRL_GAINEN] && sampTick && !peakMatch) begin
			if (peakHigh && st_q.gainCode != GAIN_CODE_MAX) begin
				st_d.gainCode = st_q.gainCode + 10'h001;
			end else if (!peakHigh && st_q.gainCode != GAIN_CODE_RST) begin
				st_d.gainCode = st_q.gainCode - 10'h001;
			end
		end
		// carrier drive: own field, or active answer in target role
		if ((st_q.role == ROLE_INIT || st_q.role == ROLE_XCHG) && !txEnvelope) begin
			st_d.txA = carrierClk ^ st_q.txCfg[TX_INVA];
			st_d.txB = carrierClk ^ st_q.txCfg[TX_INVB];
		end else if (st_q.role == ROLE_TARGET && st_q.ctrl[CTRL_ACTMOD]
			&& extFieldDet && loadModData) begin
			st_d.txA = ~carrierClk;
			st_d.txB = ~carrierClk;
		end else begin
			st_d.txA = 1'b0;
			st_d.txB = 1'b0;
		end
		// read data captured in the address phase
		st_d.rdata = 32'h0000_0000;
		case (haddr)
			OFS_CTRL:  st_d.rdata[9:0]  = st_q.ctrl;
			OFS_TXCFG: st_d.rdata[5:0]  = st_q.txCfg;
			OFS_RXCFG: st_d.rdata[7:0]  = st_q.rxCfg;
			OFS_SENSE: st_d.rdata[15:0] = st_q.sense;
			OFS_STATUS: begin
				st_d.rdata[ST_ROLE +: 2]  = st_q.role;
				st_d.rdata[ST_FIELD]      = fieldOn;
				st_d.rdata[ST_EXT]        = extFieldDet;
				st_d.rdata[ST_MODEA]      = st_q.modeA;
				st_d.rdata[ST_MODEALT]    = st_q.modeAlt;
				st_d.rdata[ST_TAG]        = st_q.tagFlag;
				st_d.rdata[ST_TXN]        = txnActive;
				st_d.rdata[ST_GAIN +: 10] = st_q.gainCode;
			end
			default: ;
		endcase
	end

	// register the whole state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q          <= '0;
			st_q.role     <= ROLE_TARGET;
			st_q.ctrl     <= 10'h0C0;     // both channels on
			st_q.rxCfg    <= {GAIN_DB_MIN, 2'h0};
			st_q.gainCode <= GAIN_CODE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = st_q.rdata;
	assign tx_out_a   = st_q.txA;
	assign tx_out_b   = st_q.txB;
	assign fieldOn    = (st_q.role == ROLE_INIT) || (st_q.role == ROLE_XCHG);
	assign levelDetEn = st_q.ctrl[CTRL_P2PEN] || st_q.role != ROLE_TARGET;
	assign initStart  = st_q.initPulse;
	assign initMode   = st_q.ctrl[CTRL_RATE +: 2];
	assign framingAlt = st_q.ctrl[CTRL_RATE +: 2] != RATE_106;
	assign fullMod    = st_q.txCfg[TX_FULLMOD];
	assign modLevel   = st_q.txCfg[TX_AMLVL +: 3];
	assign hpfSel     = st_q.rxCfg[RX_HPF +: 2];
	assign bbaGainDb  = st_q.rxCfg[RX_GAIN +: 6];
	assign chanIEn    = st_q.ctrl[CTRL_CHI] || st_q.ctrl[CTRL_ADCCARD];
	assign chanQEn    = st_q.ctrl[CTRL_CHQ] && !st_q.ctrl[CTRL_ADCCARD];
	assign gain_resistor_code       = st_q.gainCode;
	assign passive_field_modulation = !st_q.ctrl[CTRL_ACTMOD] && loadModData;
	assign active_field_modulation  = st_q.ctrl[CTRL_ACTMOD] && loadModData;
	assign tagSensed  = st_q.tagFlag;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	rate_lock_a: assert property (txnActive |=> $stable(initMode))
		else $error("rate changed in a transaction");
	reset_target_a: assert property ($past(rst) |-> (st_q.role == ROLE_TARGET) && !fieldOn)
		else $error("not target after reset");
	level_det_a: assert property (fieldOn |-> levelDetEn)
		else $error("level detector off while in initiator role");
	req_only_a: assert property ((st_q.role == ROLE_LISTEN) && $past(st_q.role == ROLE_TARGET)
		|-> $past(st_q.ctrl[CTRL_INITREQ]))
		else $error("initiator role without request");
	field_quiet_a: assert property ($rose(fieldOn) |-> !$past(extFieldDet)
		&& $past(st_q.idtCnt) == 16'(IdtCycles - 1))
		else $error("field on before quiet delay");
	init_start_a: assert property ($rose(fieldOn) |-> initStart ##1 !initStart)
		else $error("no initialization pulse");
	framing_sel_a: assert property (framingAlt == (initMode != RATE_106))
		else $error("framing not matching rate");
	gain_step_a: assert property (!$stable(gain_resistor_code) |->
		(gain_resistor_code == $past(gain_resistor_code) + 10'h001) ||
		(gain_resistor_code == $past(gain_resistor_code) - 10'h001))
		else $error("gain code moved more than one step");
	gain_sat_a: assert property (gain_resistor_code == GAIN_CODE_MAX && peakHigh
		|=> gain_resistor_code == GAIN_CODE_MAX)
		else $error("gain code wrapped");
	card_chan_a: assert property (st_q.ctrl[CTRL_ADCCARD] |-> chanIEn && !chanQEn)
		else $error("card mode uses quadrature channel");
	tag_flag_a: assert property (tagHit |=> tagSensed [*2])
		else $error("tag sense flag lost");

	listen_init_c: cover property (st_q.role == ROLE_LISTEN ##[1:600] initStart);
	gain_up_c: cover property ($rose(gain_resistor_code[0]) ##[1:40] peakMatch);
	tag_seen_c: cover property ($rose(tagSensed));
	mode_alt_c: cover property ($rose(st_q.modeAlt));

endmodule : nfcfc_top

/* File: test/nfcfc_peer_model.sv */
// Purpose: remote reader, card or peer as seen from the antenna
// Assumes: bench tells it when to raise its field and what it sends
// Notes:   demod hints only exist while the remote field is up
`timescale 1ns/1ps
module nfcfc_peer_model (
	input  wire logic       core_clk,
	input  wire logic       fieldReq,    // remote field wanted
	input  wire logic       protoA,      // 1 = type a initiator
	input  wire logic [7:0] detuneReq,   // detuning the antenna shows
	output logic            extFieldDet,
	output logic            modeIsTypeA,
	output logic            modeIsAlt,
	output logic [7:0]      detuneLevel
);
	// ****************************************************************
	// field and hints, one cycle behind the request
	// ****************************************************************
	// hints drop with the field, never left standing
	always_ff @(posedge core_clk) begin
		extFieldDet <= fieldReq;
		modeIsTypeA <= fieldReq & protoA;
		modeIsAlt   <= fieldReq & ~protoA;
		detuneLevel <= detuneReq;
	end
endmodule : nfcfc_peer_model

/* File: test/test_nfc_frontend_control.sv */
// Purpose: self-checking bench for the front end control block
// Assumes: 100 MHz clock, zero-wait AHB-Lite slave
// Notes:   listen window shortened to 20 cycles
`timescale 1ns/1ps
module test_nfc_frontend_control;
	import nfcfc_pkg::*;
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int Idt = 20; // shortened listen window
	logic        core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [7:0]  haddr, detuneReq, detuneLevel;
	logic [1:0]  htrans, initMode, hpfSel;
	logic [2:0]  hsize, modLevel;
	logic [31:0] hwdata, hrdata, rdv;
	logic        carrierClk, txEnvelope, extFieldDet, peakHigh, peakMatch;
	logic        modeIsTypeA, modeIsAlt, initDone, tgtSession, loadModData;
	logic        fieldReq, protoA, tx_out_a, tx_out_b, fieldOn, levelDetEn;
	logic        initStart, framingAlt, fullMod, chanIEn, chanQEn, tagSensed;
	logic        passive_field_modulation, active_field_modulation;
	logic [5:0]  bbaGainDb;
	logic [9:0]  gain_resistor_code;
	int          mismatches, compares, cnt;
	logic [9:0]  chCtrl [4] = '{10'h040, 10'h080, 10'h1C0, 10'h000}; // channel cases
	logic [1:0]  chExp [4]  = '{2'h2, 2'h1, 2'h2, 2'h0};             // {I, Q}
	logic [7:0]  dtv [4]    = '{8'h85, 8'h90, 8'h70, 8'h6F};         // detune steps
	assign hready = hreadyout; // single slave
	nfcfc_top #(.IdtCycles(Idt)) dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.carrierClk(carrierClk), .txEnvelope(txEnvelope), .extFieldDet(extFieldDet),
		.peakHigh(peakHigh), .peakMatch(peakMatch), .modeIsTypeA(modeIsTypeA),
		.modeIsAlt(modeIsAlt), .initDone(initDone), .tgtSession(tgtSession),
		.loadModData(loadModData), .detuneLevel(detuneLevel), .tx_out_a(tx_out_a),
		.tx_out_b(tx_out_b), .fieldOn(fieldOn), .levelDetEn(levelDetEn),
		.initStart(initStart), .initMode(initMode), .framingAlt(framingAlt),
		.fullMod(fullMod), .modLevel(modLevel), .hpfSel(hpfSel), .bbaGainDb(bbaGainDb),
		.chanIEn(chanIEn), .chanQEn(chanQEn), .gain_resistor_code(gain_resistor_code),
		.passive_field_modulation(passive_field_modulation),
		.active_field_modulation(active_field_modulation), .tagSensed(tagSensed));
	nfcfc_peer_model peer (.core_clk(core_clk), .fieldReq(fieldReq), .protoA(protoA),
		.detuneReq(detuneReq), .extFieldDet(extFieldDet), .modeIsTypeA(modeIsTypeA),
		.modeIsAlt(modeIsAlt), .detuneLevel(detuneLevel));
	// ****************************************************************
	// tasks
	// ****************************************************************
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one single transfer, address phase then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'h2};
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rdv = hrdata;
	endtask : xfer
	// verdict and end of run
	task automatic wrap_up();
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// ****************************************************************
	// clock, watchdog, tests
	// ****************************************************************
	always #5 core_clk = ~core_clk;
	// hang guard, run needs about 17k cycles
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
	initial begin
		{core_clk, rst, hsel, hwrite, htrans, haddr, hwdata} = {2'b01, 44'h0};
		hsize = 3'h2;
		{carrierClk, txEnvelope, peakHigh, peakMatch, initDone, tgtSession} = 6'h00;
		{loadModData, fieldReq, protoA, detuneReq} = {3'b000, 8'h80};
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		// reset values and unmapped place
		xfer(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("ctrlRst", rdv, 32'h0000_00C0);
		xfer(1'b0, OFS_RXCFG, 32'h0000_0000);
		chk("rxRst", rdv, 32'h0000_0078);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("statRst", rdv, 32'h0000_0000);
		xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
		xfer(1'b0, 8'h20, 32'h0000_0000);
		chk("unmapped", rdv, 32'h0000_0000);
		@(negedge core_clk);
		chk("fieldRst", 32'({fieldOn, tx_out_a, tx_out_b}), 32'h0000_0000);
		chk("codeRst", 32'(gain_resistor_code), 32'(GAIN_CODE_RST));
		chk("busOkay", 32'({hreadyout, hresp}), 32'h0000_0002);
		// every rate, code 3 reads as 424
		for (int r = 0; r < 4; r++) begin
			xfer(1'b1, OFS_CTRL, 32'(r) << 2);
			@(negedge core_clk);
			chk("initMode", 32'(initMode), (r == 3) ? 32'(RATE_424) : 32'(r));
			chk("framing", 32'(framingAlt), 32'(r != 0));
		end
		// rate frozen while a target transaction is open
		@(posedge core_clk);
		tgtSession <= 1'b1;
		xfer(1'b1, OFS_CTRL, 32'h0000_0004);
		@(negedge core_clk);
		chk("rateHeld", 32'(initMode), 32'(RATE_424));
		@(posedge core_clk);
		tgtSession <= 1'b0;
		xfer(1'b1, OFS_CTRL, 32'h0000_0004);
		@(negedge core_clk);
		chk("rateFree", 32'(initMode), 32'(RATE_212));
		// four corners, gain range and clamps
		for (int h = 0; h < 4; h++) begin
			xfer(1'b1, OFS_RXCFG, 32'((45 << 2) | h));
			@(negedge core_clk);
			chk("hpf", 32'({bbaGainDb, hpfSel}), 32'((45 << 2) | h));
		end
		xfer(1'b1, OFS_RXCFG, 32'h0000_0050);
		@(negedge core_clk);
		chk("gainLo", 32'(bbaGainDb), 32'(GAIN_DB_MIN));
		xfer(1'b1, OFS_RXCFG, 32'h0000_00FC);
		@(negedge core_clk);
		chk("gainHi", 32'(bbaGainDb), 32'(GAIN_DB_MAX));
		// all partial levels, full modulation toggled
		for (int l = 0; l < 8; l++) begin
			xfer(1'b1, OFS_TXCFG, 32'((l << 3) | ((l & 1) << 2)));
			@(negedge core_clk);
			chk("modLvl", 32'({modLevel, fullMod}), 32'((l << 1) | (l & 1)));
		end
		// independent channels, card mode keeps I only
		for (int c = 0; c < 4; c++) begin
			xfer(1'b1, OFS_CTRL, 32'(chCtrl[c]));
			@(negedge core_clk);
			chk("chan", 32'({chanIEn, chanQEn}), 32'(chExp[c]));
		end
		// gain loop: floor, single steps, hold, ceiling
		xfer(1'b1, OFS_CTRL, 32'h0000_0020);
		repeat (40) @(negedge core_clk);
		chk("codeFloor", 32'(gain_resistor_code), 32'h0000_0000);
		@(posedge core_clk);
		peakHigh <= 1'b1;
		cnt = 0;
		while (gain_resistor_code !== 10'h001 && cnt < 40) begin
			@(negedge core_clk);
			cnt++;
		end
		chk("stepWait", 32'(cnt < 40), 32'h0000_0001);
		repeat (16) @(negedge core_clk);
		chk("codeStep", 32'(gain_resistor_code), 32'h0000_0002);
		@(posedge core_clk);
		peakMatch <= 1'b1;
		repeat (48) @(negedge core_clk);
		chk("codeHold", 32'(gain_resistor_code), 32'h0000_0002);
		@(posedge core_clk);
		peakMatch <= 1'b0;
		repeat (1024 * 16) @(negedge core_clk);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("codeCeil", 32'(rdv[25:16]), 32'(GAIN_CODE_MAX));
		@(posedge core_clk);
		peakHigh <= 1'b0;
		repeat (16) @(negedge core_clk);
		chk("codeDown", 32'(gain_resistor_code), 32'h0000_03FE);
		// peer to peer: detector on, no initiator without request
		xfer(1'b1, OFS_CTRL, 32'h0000_0002);
		repeat (Idt + 5) @(negedge core_clk);
		chk("detOn", 32'({levelDetEn, fieldOn}), 32'h0000_0002);
		@(posedge core_clk);
		{fieldReq, carrierClk} <= 2'b11;
		xfer(1'b1, OFS_TXCFG, 32'h0000_0002);
		xfer(1'b1, OFS_CTRL, 32'h0000_000B);
		repeat (2 * Idt) @(negedge core_clk);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("listen", 32'({fieldOn, rdv[2:0]}), 32'h0000_0001);
		@(posedge core_clk);
		fieldReq <= 1'b0;
		cnt = 0;
		while (fieldOn !== 1'b1 && cnt < 100) begin
			@(negedge core_clk);
			cnt++;
		end
		chk("quietMin", 32'(cnt >= Idt && cnt <= Idt + 4), 32'h0000_0001);
		chk("initGo", 32'({initStart, initMode}), 32'h0000_0006);
		@(negedge core_clk);
		chk("initPulse", 32'(initStart), 32'h0000_0000);
		chk("txInvB", 32'({tx_out_a, tx_out_b}), 32'h0000_0002);
		@(posedge core_clk);
		carrierClk <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk("txLow", 32'({tx_out_a, tx_out_b}), 32'h0000_0001);
		@(posedge core_clk);
		txEnvelope <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk("txPause", 32'({tx_out_a, tx_out_b}), 32'h0000_0000);
		xfer(1'b1, OFS_CTRL, 32'h0000_0007);
		@(negedge core_clk);
		chk("rateLock", 32'({framingAlt, initMode}), 32'h0000_0006);
		@(posedge core_clk);
		initDone <= 1'b1;
		@(posedge core_clk);
		initDone <= 1'b0;
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("xchg", 32'({rdv[7], rdv[2:0]}), 32'h0000_000F);
		xfer(1'b1, OFS_CTRL, 32'h0000_0000);
		// role follows the new control word one edge after the write lands
		repeat (2) @(negedge core_clk);
		chk("backTgt", 32'({fieldOn, tx_out_a, tx_out_b}), 32'h0000_0000);
		// target: mode detector and active modulation
		@(posedge core_clk);
		{fieldReq, protoA, carrierClk, txEnvelope, loadModData} <= 5'b11101;
		xfer(1'b1, OFS_CTRL, 32'h0000_0010);
		repeat (3) @(negedge core_clk);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("modeA", 32'(rdv[5:3]), 32'h0000_0003);
		@(negedge core_clk);
		chk("almSel", 32'({active_field_modulation, passive_field_modulation}), 32'h0000_0002);
		chk("almTx", 32'({tx_out_a, tx_out_b}), 32'h0000_0000);
		@(posedge core_clk);
		{fieldReq, carrierClk} <= 2'b00;
		repeat (4) @(negedge core_clk);
		@(posedge core_clk);
		{fieldReq, protoA} <= 2'b10;
		repeat (4) @(negedge core_clk);
		chk("almInv", 32'({tx_out_a, tx_out_b}), 32'h0000_0003);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("modeAlt", 32'(rdv[5:3]), 32'h0000_0005);
		xfer(1'b1, OFS_CTRL, 32'h0000_0000);
		@(negedge core_clk);
		chk("plmSel", 32'({active_field_modulation, passive_field_modulation}), 32'h0000_0001);
		// tag sense: threshold edge, flag, write-one clear
		@(posedge core_clk);
		{fieldReq, loadModData} <= 2'b00;
		xfer(1'b1, OFS_SENSE, 32'h0000_8010);
		xfer(1'b1, OFS_CTRL, 32'h0000_0200);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			detuneReq <= dtv[i];
			repeat (4) @(negedge core_clk);
			chk("tagSense", 32'(tagSensed), 32'(i == 3));
		end
		@(posedge core_clk);
		detuneReq <= 8'h80;
		xfer(1'b1, OFS_STATUS, 32'h0000_0043);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("tagClear", 32'({tagSensed, rdv[6], rdv[1:0]}), 32'h0000_0000);
		wrap_up();
	end
endmodule : test_nfc_frontend_control
